// *** hw/csg_aux_pins.sv ***
// Aux pin signal generator: driver enable framing, activity LEDs, power pins,
// clock output, ring wakeup and oscillator select, with an AHB-Lite register slave.
// Assumes a single 250 MHz clock; USB state and user data come from the same domain.
//
// The placing of the registers and register access over AHB-Lite were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "csg_regs.svh"

// Functional notes
// - Driver enable rises one full bit period before the start bit.
// - Driver enable falls as the stop bit begins; neither point is adjustable.
// - LED pins float when idle and drive low during transfers.
// - LED indications are stretched by a digital one-shot.
// - Each aux pin selects tx, rx or combined LED from its stored code.
// - Combined LED shows activity in either direction.
// - Power enable goes high during USB suspend.
// - Sleep output is high when active, low in suspend.
// - An aux pin can output a continuous 12 MHz clock.
// - Default: pin two is driver enable, pin three is power enable.
// - Data on transmit and receive lines; RTS and CTS handshake honoured.
// - Ring input lets an external agent request remote wakeup of the host.
// - Baud rate never exceeds 3 Mbaud.
// - Internal oscillator by default; external only when configured.
// - With no oscillator source the device has no clock and stops.
// - Power enable goes low after enumeration, high again in suspend.
// - A falling ring while enabled wakes the suspended host for about 20 ms.
module csg_aux_pins
   import csg_pkg::*;
#(
   parameter int STRETCH_CYCLES = `CSG_STRETCH_CYCLES,
   parameter int WAKE_CYCLES    = `CSG_WAKE_CYCLES,
   parameter int DATA_BITS      = `CSG_DATA_BITS
) (
   // Clock and reset.
   input  wire logic                      CLK,
   input  wire logic                      RST_B,
   // AHB-Lite slave.
   input  wire logic                      HSEL,
   input  wire logic [31:0]               HADDR,
   input  wire logic [1:0]                HTRANS,
   input  wire logic                      HWRITE,
   input  wire logic [2:0]                HSIZE,
   input  wire logic [31:0]               HWDATA,
   input  wire logic                      HREADY,
   output var  logic [31:0]               HRDATA,
   output var  logic                      HREADYOUT,
   output var  logic                      HRESP,
   // Transmit characters from the bridge.
   input  wire logic [DATA_BITS-1:0]      TX_DATA,
   input  wire logic                      TX_VALID,
   output var  logic                      TX_READY,
   input  wire logic                      RX_READY,
   // Serial pins.
   output var  logic                      TXD,
   input  wire logic                      RXD,
   output var  logic                      RTS_N,
   input  wire logic                      CTS_N,
   input  wire logic                      RI_N,
   // USB state and wakeup.
   input  wire logic                      USB_SUSPEND,
   input  wire logic                      USB_CONFIGURED,
   output var  logic                      REMOTE_WAKE,
   // Oscillator source select.
   output var  logic                      OSC_EXT_SEL,
   // Configurable aux pins.
   output var  logic [`CSG_NUM_PINS-1:0]  AUX_PIN_O,
   output var  logic [`CSG_NUM_PINS-1:0]  AUX_PIN_OE
);

   // ********************
   // Declarations
   // ********************
   localparam int BW = $clog2(DATA_BITS + 1);
   localparam int WW = $clog2(WAKE_CYCLES + 1);
   localparam logic [`CSG_DIV_W-1:0] MIN_DIV = `CSG_DIV_W'(`CSG_MIN_DIV);

   logic [31:0]                  ctrl_q;
   logic [`CSG_PINCFG_W-1:0]     pincfg_q;
   logic                         wr_pend_q;
   logic [7:0]                   wr_addr_q;
   logic                         addr_phase;
   logic [31:0]                  rd_mux;
   logic [31:0]                  status;

   logic [`CSG_DIV_W-1:0]        div_eff;
   csg_tx_e                      tx_state_q;
   logic [`CSG_DIV_W-1:0]        baud_cnt_q;
   logic [BW-1:0]                bit_cnt_q;
   logic [DATA_BITS-1:0]         shift_q;
   logic                         cell_end;
   logic                         tx_driver_enable;
   logic                         tx_busy;

   logic                         cts_n_s;
   logic                         rxd_s;
   logic                         ri_n_s;
   logic                         ri_n_prev_q;
   logic                         tx_led_on;
   logic                         rx_led_on;
   logic                         txrx_led_on;
   logic                         power_enable_n;
   logic                         sleep_n;
   logic [8:0]                   clk_acc_q;
   logic                         clk12_q;
   logic [WW-1:0]                wake_cnt_q;

   // ********************
   // AHB-Lite register slave
   // ********************
   // Zero-wait slave: read data is registered in the address phase so the
   // data phase can complete at once, always with an OKAY response.
   assign HREADYOUT  = 1'b1;
   assign HRESP      = 1'b0;
   assign addr_phase = HSEL && HREADY && HTRANS[1];

   // Address phase of a write is held until its data phase.
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= `CSG_OFS_CTRL;
      end
      else if (HREADY)
      begin
         wr_pend_q <= addr_phase && HWRITE;
         wr_addr_q <= HADDR[7:0];
      end
   end

   // Configuration writes; defaults stand in for unprogrammed storage.
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         ctrl_q   <= `CSG_CTRL_RST;
         pincfg_q <= `CSG_PINCFG_RST;
      end
      else if (wr_pend_q)
      begin
         if (wr_addr_q == `CSG_OFS_CTRL)
            ctrl_q <= {14'h0000, HWDATA[`CSG_CTRL_EXT_OSC:0]};
         else if (wr_addr_q == `CSG_OFS_PINCFG)
            pincfg_q <= HWDATA[`CSG_PINCFG_W-1:0];
      end
   end

   // Status shows the block's own live state.
   assign status = {22'h000000, wake_cnt_q != '0, ri_n_s, cts_n_s, rxd_s,
                    txrx_led_on, rx_led_on, tx_led_on, tx_driver_enable,
                    USB_CONFIGURED, USB_SUSPEND};

   // Unmapped offsets read as zero.
   always_comb
   begin
      case (HADDR[7:0])
         `CSG_OFS_CTRL:   rd_mux = ctrl_q;
         `CSG_OFS_PINCFG: rd_mux = {12'h000, pincfg_q};
         `CSG_OFS_STATUS: rd_mux = status;
         default:         rd_mux = 32'h00000000;
      endcase
   end

   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
         HRDATA <= 32'h00000000;
      else if (addr_phase && !HWRITE)
         HRDATA <= rd_mux;
   end

   // ********************
   // Pin synchronisers
   // ********************
   csg_pin_sync #(.RST_VAL(1'b1)) u_sync_cts (
      .clk   (CLK),
      .rst_b (RST_B),
      .pin   (CTS_N),
      .level (cts_n_s)
   );

   // With echo suppression outside, receive stays high while we drive.
   csg_pin_sync #(.RST_VAL(1'b1)) u_sync_rxd (
      .clk   (CLK),
      .rst_b (RST_B),
      .pin   (RXD),
      .level (rxd_s)
   );

   csg_pin_sync #(.RST_VAL(1'b1)) u_sync_ri (
      .clk   (CLK),
      .rst_b (RST_B),
      .pin   (RI_N),
      .level (ri_n_s)
   );

   // ********************
   // Character framing and driver enable
   // ********************
   // Software divisors below the floor are raised to it, capping the rate.
   assign div_eff  = (ctrl_q[`CSG_DIV_W-1:0] < MIN_DIV) ? MIN_DIV
                                                        : ctrl_q[`CSG_DIV_W-1:0];
   assign cell_end = (baud_cnt_q == '0);

   // A character starts only when the far end grants clear-to-send.
   assign TX_READY = (tx_state_q == CSG_TX_IDLE) && !cts_n_s;
   // Receiver space is advertised on request-to-send, active low.
   assign RTS_N    = !RX_READY;

   // One cell counter times the lead cell and every bit cell alike.
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
         baud_cnt_q <= '0;
      else if (tx_state_q == CSG_TX_IDLE || cell_end)
         baud_cnt_q <= div_eff - 1'b1;
      else
         baud_cnt_q <= baud_cnt_q - 1'b1;
   end

   // Lead cell, start bit, data bits, stop bit.
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         tx_state_q <= CSG_TX_IDLE;
         bit_cnt_q  <= '0;
         shift_q    <= '0;
         TXD        <= 1'b1;
      end
      else
      begin
         case (tx_state_q)
            CSG_TX_IDLE:
               if (TX_VALID && TX_READY)
               begin
                  shift_q    <= TX_DATA;
                  tx_state_q <= CSG_TX_LEAD;
               end
            CSG_TX_LEAD:
               if (cell_end)
               begin
                  TXD        <= 1'b0;
                  tx_state_q <= CSG_TX_START;
               end
            CSG_TX_START:
               if (cell_end)
               begin
                  TXD        <= shift_q[0];
                  shift_q    <= shift_q >> 1;
                  bit_cnt_q  <= BW'(1);
                  tx_state_q <= CSG_TX_DATA;
               end
            CSG_TX_DATA:
               if (cell_end)
               begin
                  if (bit_cnt_q == BW'(DATA_BITS))
                  begin
                     TXD        <= 1'b1;
                     tx_state_q <= CSG_TX_STOP;
                  end
                  else
                  begin
                     TXD       <= shift_q[0];
                     shift_q   <= shift_q >> 1;
                     bit_cnt_q <= bit_cnt_q + 1'b1;
                  end
               end
            CSG_TX_STOP:
               if (cell_end)
                  tx_state_q <= CSG_TX_IDLE;
            default:
               tx_state_q <= CSG_TX_IDLE;
         endcase
      end
   end

   // Fixed lead and release points; no register can move them.
   assign tx_driver_enable = (tx_state_q == CSG_TX_LEAD) ||
                             (tx_state_q == CSG_TX_START) ||
                             (tx_state_q == CSG_TX_DATA);
   assign tx_busy          = (tx_state_q != CSG_TX_IDLE) &&
                             (tx_state_q != CSG_TX_LEAD);

   // ********************
   // Activity LEDs
   // ********************
   // Stretching keeps single short characters visible to the eye.
   csg_one_shot #(.STRETCH(STRETCH_CYCLES)) u_shot_tx (
      .clk    (CLK),
      .rst_b  (RST_B),
      .trig   (tx_busy),
      .active (tx_led_on)
   );

   csg_one_shot #(.STRETCH(STRETCH_CYCLES)) u_shot_rx (
      .clk    (CLK),
      .rst_b  (RST_B),
      .trig   (!rxd_s),
      .active (rx_led_on)
   );

   assign txrx_led_on = tx_led_on || rx_led_on;

   // ********************
   // Power pins
   // ********************
   // Unconfigured devices keep external logic off until enumeration.
   assign power_enable_n = !(USB_CONFIGURED && !USB_SUSPEND);
   assign sleep_n        = !USB_SUSPEND;

   // ********************
   // Clock output
   // ********************
   // 250 is not a multiple of 24, so a phase accumulator is used; the
   // average is exact but single periods jitter by one core cycle.
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         clk_acc_q <= '0;
         clk12_q   <= 1'b0;
      end
      else if (clk_acc_q + `CSG_CLKOUT_STEP >= `CSG_CLK_MHZ)
      begin
         clk_acc_q <= clk_acc_q + `CSG_CLKOUT_STEP - `CSG_CLK_MHZ;
         clk12_q   <= !clk12_q;
      end
      else
         clk_acc_q <= clk_acc_q + `CSG_CLKOUT_STEP;
   end

   // ********************
   // Ring wakeup
   // ********************
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
         ri_n_prev_q <= 1'b1;
      else
         ri_n_prev_q <= ri_n_s;
   end

   // A falling ring while suspended and enabled holds resume signalling.
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
         wake_cnt_q <= '0;
      else if (ri_n_prev_q && !ri_n_s && USB_SUSPEND && ctrl_q[`CSG_CTRL_WAKE_EN])
         wake_cnt_q <= WW'(WAKE_CYCLES);
      else if (wake_cnt_q != '0)
         wake_cnt_q <= wake_cnt_q - 1'b1;
   end

   assign REMOTE_WAKE = (wake_cnt_q != '0);

   // ********************
   // Oscillator select
   // ********************
   // Internal source unless software has enabled the external one; with
   // neither present nothing here can run, so no fallback is attempted.
   assign OSC_EXT_SEL = ctrl_q[`CSG_CTRL_EXT_OSC];

   // ********************
   // Aux pin multiplexer
   // ********************
   // LEDs are open-drain style: driven low only while lit, else floating.
   always_comb
   begin
      for (int i = 0; i < `CSG_NUM_PINS; i++)
      begin
         AUX_PIN_O[i]  = 1'b0;
         AUX_PIN_OE[i] = 1'b1;
         case (csg_fn_e'(pincfg_q[i*`CSG_FN_W +: `CSG_FN_W]))
            CSG_FN_TX_ACTIVITY_LED_N:   AUX_PIN_OE[i] = tx_led_on;
            CSG_FN_RX_ACTIVITY_LED_N:   AUX_PIN_OE[i] = rx_led_on;
            CSG_FN_TXRXLED: AUX_PIN_OE[i] = txrx_led_on;
            CSG_FN_TX_DRIVER_ENABLE:   AUX_PIN_O[i]  = tx_driver_enable;
            CSG_FN_POWER_ENABLE_N:   AUX_PIN_O[i]  = power_enable_n;
            CSG_FN_SLEEP:   AUX_PIN_O[i]  = sleep_n;
            CSG_FN_CLK12:   AUX_PIN_O[i]  = clk12_q;
            default:        AUX_PIN_OE[i] = 1'b0;
         endcase
      end
   end

endmodule : csg_aux_pins

`default_nettype wire

// *** common/csg_regs.svh ***
// Register map, field positions, reset values and timing figures of the aux pin generator.
// Assumes a 250 MHz core clock and 32-bit AHB-Lite word registers.
`ifndef CSG_REGS_SVH
`define CSG_REGS_SVH

// ********************
// Register byte offsets
// ********************
`define CSG_OFS_CTRL        8'h00
`define CSG_OFS_PINCFG      8'h04
`define CSG_OFS_STATUS      8'h08

// ********************
// Field layout
// ********************
`define CSG_DIV_W           16
`define CSG_CTRL_WAKE_EN    16
`define CSG_CTRL_EXT_OSC    17
`define CSG_FN_W            4
`define CSG_NUM_PINS        5
`define CSG_PINCFG_W        20

// ********************
// Reset values
// ********************
// Divisor for 115200 baud at 250 MHz, remote wakeup enabled.
`define CSG_CTRL_RST        32'h0001087A
// Pins 4..0: sleep, power enable, driver enable, rx led, tx led.
`define CSG_PINCFG_RST      20'h54310

// ********************
// Timing
// ********************
`define CSG_CLK_HZ          250000000
`define CSG_CLK_MHZ         9'h0FA
`define CSG_MAX_BAUD        3000000
`define CSG_MIN_DIV         ((`CSG_CLK_HZ + `CSG_MAX_BAUD - 1) / `CSG_MAX_BAUD)
`define CSG_CLKOUT_STEP     9'h018
`define CSG_WAKE_MS         20
`define CSG_WAKE_CYCLES     (`CSG_WAKE_MS * (`CSG_CLK_HZ / 1000))
`define CSG_STRETCH_CYCLES  4000000
`define CSG_DATA_BITS       8

`endif

// *** common/csg_pkg.sv ***
// Types shared by the aux pin generator modules.
// Assumes csg_regs.svh for all numeric figures.
`default_nettype none

package csg_pkg;

   // Function codes of one configurable aux pin, in stored encoding order.
   typedef enum logic [3:0] {
      CSG_FN_TX_ACTIVITY_LED_N,
      CSG_FN_RX_ACTIVITY_LED_N,
      CSG_FN_TXRXLED,
      CSG_FN_TX_DRIVER_ENABLE,
      CSG_FN_POWER_ENABLE_N,
      CSG_FN_SLEEP,
      CSG_FN_CLK12,
      CSG_FN_OFF
   } csg_fn_e;

   // Character framing states of the transmitter.
   typedef enum logic [2:0] {
      CSG_TX_IDLE,
      CSG_TX_LEAD,
      CSG_TX_START,
      CSG_TX_DATA,
      CSG_TX_STOP
   } csg_tx_e;

endpackage : csg_pkg

`default_nettype wire

// *** hw/csg_pin_sync.sv ***
// Three-stage synchroniser for a pin from outside the clock domain.
// Assumes the pin is a level; output moves only when stages two and three agree.
`timescale 1ns/100ps
`default_nettype none

module csg_pin_sync #(
   parameter logic RST_VAL = 1'b1
) (
   // Clock and reset.
   input  wire logic clk,
   input  wire logic rst_b,
   // Pin and its clean level.
   input  wire logic pin,
   output var  logic level
);

   logic s1_q;
   logic s2_q;
   logic s3_q;

   // Stage one feeds stage two only, to contain metastability.
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         s1_q <= RST_VAL;
         s2_q <= RST_VAL;
         s3_q <= RST_VAL;
      end
      else
      begin
         s1_q <= pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // A change counts once the later two stages agree.
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         level <= RST_VAL;
      else if (s2_q == s3_q)
         level <= s3_q;
   end

endmodule : csg_pin_sync

`default_nettype wire

// *** hw/csg_one_shot.sv ***
// Retriggerable one-shot that stretches activity into a visible pulse.
// Assumes trig is synchronous to clk.
`timescale 1ns/100ps
`default_nettype none

module csg_one_shot #(
   parameter int STRETCH = 4000000
) (
   // Clock and reset.
   input  wire logic clk,
   input  wire logic rst_b,
   // Trigger and stretched output.
   input  wire logic trig,
   output var  logic active
);

   localparam int CW = $clog2(STRETCH + 1);
   logic [CW-1:0] cnt_q;

   // Each trigger reloads the full interval, so a busy line stays lit.
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         cnt_q <= '0;
      else if (trig)
         cnt_q <= CW'(STRETCH);
      else if (cnt_q != '0)
         cnt_q <= cnt_q - 1'b1;
   end

   assign active = trig || (cnt_q != '0);

endmodule : csg_one_shot

`default_nettype wire

// *** sim/csg_aux_monitor.sv ***
// Port checker of the aux pin generator, bound into its top module.
// Assumes bench writes keep pins two to four on their default functions.
`timescale 1ns/100ps
`default_nettype none
`include "csg_regs.svh"

// ********************
// Checker
// ********************
module csg_aux_monitor #(
   parameter int WAKE_CYCLES = 30
) (
   // Clock, reset and bus.
   input wire logic        CLK,
   input wire logic        RST_B,
   input wire logic        HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0]  HTRANS,
   input wire logic        HWRITE,
   input wire logic [31:0] HWDATA,
   input wire logic        HREADY,
   // Pins and USB state.
   input wire logic        TX_READY,
   input wire logic        TXD,
   input wire logic        CTS_N,
   input wire logic        RI_N,
   input wire logic        USB_SUSPEND,
   input wire logic        USB_CONFIGURED,
   input wire logic        REMOTE_WAKE,
   input wire logic        OSC_EXT_SEL,
   input wire logic [`CSG_NUM_PINS-1:0] AUX_PIN_O
);
   logic        wr_q;
   logic [31:0] ctrl_q;
   int          den_q;
   int          wake_q;
   int          bit_w;

   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_B);

   // Bit cell length; slower settings pass, faster ones are clamped.
   assign bit_w = (ctrl_q[15:0] < 16'h0054) ? 84 : int'(ctrl_q[15:0]);

   // Control shadow and high-time counters; a write lands in its data phase.
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         wr_q   <= 1'b0;
         ctrl_q <= 32'h0001087A;
         den_q  <= 0;
         wake_q <= 0;
      end
      else
      begin
         wr_q   <= HSEL && HREADY && HTRANS[1] && HWRITE && HADDR[7:0] == 8'h00;
         ctrl_q <= wr_q ? HWDATA : ctrl_q;
         den_q  <= AUX_PIN_O[2] ? den_q + 1 : 0;
         wake_q <= REMOTE_WAKE ? wake_q + 1 : 0;
      end
   end

   sequence s_asleep;
      USB_SUSPEND [*2];
   endsequence
   sequence s_awake;
      (USB_CONFIGURED && !USB_SUSPEND) [*2];
   endsequence
   sequence s_ring;
      $fell(RI_N) && USB_SUSPEND && ctrl_q[16];
   endsequence

   a_den_lead: assert property ($fell(TXD) && den_q < 2 * bit_w |-> den_q == bit_w)
      else $error("driver enable lead time wrong");
   a_den_release: assert property ($fell(AUX_PIN_O[2]) |-> TXD && den_q == 10 * bit_w)
      else $error("driver enable release wrong");
   a_pwr_off: assert property (s_asleep |-> AUX_PIN_O[3] && !AUX_PIN_O[4])
      else $error("suspend levels wrong");
   a_pwr_on: assert property (s_awake |-> !AUX_PIN_O[3] && AUX_PIN_O[4])
      else $error("awake levels wrong");
   a_wake_start: assert property (s_ring |-> ##[2:10] REMOTE_WAKE)
      else $error("remote wakeup missing");
   a_wake_len: assert property ($fell(REMOTE_WAKE) |-> wake_q == WAKE_CYCLES)
      else $error("remote wakeup length wrong");
   a_osc_select: assert property (OSC_EXT_SEL == ctrl_q[17])
      else $error("oscillator select wrong");
   a_cts_gate: assert property (CTS_N [*6] |-> !TX_READY)
      else $error("character offered while blocked");

endmodule : csg_aux_monitor

bind csg_aux_pins csg_aux_monitor #(.WAKE_CYCLES(WAKE_CYCLES)) u_csg_aux_monitor (
   .CLK(CLK), .RST_B(RST_B), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
   .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY), .TX_READY(TX_READY),
   .TXD(TXD), .CTS_N(CTS_N), .RI_N(RI_N), .USB_SUSPEND(USB_SUSPEND),
   .USB_CONFIGURED(USB_CONFIGURED), .REMOTE_WAKE(REMOTE_WAKE),
   .OSC_EXT_SEL(OSC_EXT_SEL), .AUX_PIN_O(AUX_PIN_O));

`default_nettype wire

// *** sim/csg_far_end.sv ***
// Far-end model: line transceiver and controller on the serial pins.
// Assumes the bench pulses send for one cycle with byte_in set.
`timescale 1ns/100ps
`default_nettype none

module csg_far_end #(
   parameter int BIT = 84
) (
   // Clock and bench commands.
   input  wire logic       clk,
   input  wire logic       send,
   input  wire logic [7:0] byte_in,
   input  wire logic       stall,
   input  wire logic       ring,
   // Device pins.
   input  wire logic       den,
   output logic            rxd,
   output logic            cts_n,
   output logic            ri_n
);
   logic [9:0] frame_q = 10'h3FF;
   int         cnt_q   = 0;

   // Shift one frame out LSB first; the line idles high on its pull-up.
   always_ff @(posedge clk)
   begin
      if (send)
      begin
         frame_q <= {1'b1, byte_in, 1'b0};
         cnt_q   <= 10 * BIT;
      end
      else if (cnt_q > 0)
      begin
         cnt_q   <= cnt_q - 1;
         frame_q <= (cnt_q % BIT == 1) ? {1'b1, frame_q[9:1]} : frame_q;
      end
   end

   // Echo of our own driver is masked by ORing its enable into receive.
   assign rxd   = frame_q[0] | den;
   assign cts_n = stall;
   assign ri_n  = !ring;

endmodule : csg_far_end

`default_nettype wire

// *** sim/csg_aux_pins_test.sv ***
// Self-checking bench of the aux pin generator.
// Assumes the far-end model and the bound checker are compiled first.
`timescale 1ns/100ps
`default_nettype none

module csg_aux_pins_test;
   localparam int STR = 20;
   localparam int WAK = 30;
   logic        clk = 1'b0, rst_b = 1'b0, hwrite = 1'b0, hready, hresp;
   logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
   logic [1:0]  htrans = '0;
   logic [7:0]  tx_data = '0, rx_byte = '0, got;
   logic        tx_valid = 1'b0, tx_ready, rx_ready = 1'b0, txd, rxd, rts_n;
   logic        cts_n, ri_n, susp = 1'b0, conf = 1'b0, wake, osc, p = 1'b1;
   logic        send = 1'b0, stall = 1'b0, ring = 1'b0;
   logic [4:0]  pin_o, pin_oe;
   int          num_errors = 0, checks_done = 0, div, e, n;

   // Free-running 250 MHz clock.
   always #2 clk = ~clk;

   csg_aux_pins #(.STRETCH_CYCLES(STR), .WAKE_CYCLES(WAK)) u_csg_aux_pins (
      .CLK(clk), .RST_B(rst_b), .HSEL(1'b1), .HADDR(haddr), .HTRANS(htrans),
      .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready),
      .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp), .TX_DATA(tx_data),
      .TX_VALID(tx_valid), .TX_READY(tx_ready), .RX_READY(rx_ready), .TXD(txd),
      .RXD(rxd), .RTS_N(rts_n), .CTS_N(cts_n), .RI_N(ri_n), .USB_SUSPEND(susp),
      .USB_CONFIGURED(conf), .REMOTE_WAKE(wake), .OSC_EXT_SEL(osc),
      .AUX_PIN_O(pin_o), .AUX_PIN_OE(pin_oe));
   csg_far_end u_csg_far_end (.clk(clk), .send(send), .byte_in(rx_byte),
      .stall(stall), .ring(ring), .den(pin_o[2]), .rxd(rxd), .cts_n(cts_n), .ri_n(ri_n));

   task automatic complete_run;
      if (num_errors == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : complete_run

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   // A wait that ran out of its bound ends the run.
   task automatic bound(input logic hit);
      check(hit, 1'b1);
      if (hit !== 1'b1)
         complete_run();
   endtask : bound

   // One single AHB transfer; the answer may take up to 50 cycles.
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
      htrans <= 2'h2;
      haddr  <= {24'h0, a};
      hwrite <= w;
      for (n = 0; n == 0 || (hready !== 1'b1 && n < 50); n++)
         @(posedge clk);
      bound(hready);
      htrans <= 2'h0;
      hwdata <= d;
      for (n = 0; n == 0 || (hready !== 1'b1 && n < 50); n++)
         @(posedge clk);
      bound(hready && !hresp);
      rd = hrdata;
   endtask : bus

   function automatic logic lit(input int code, input logic tx);
      return code == 2 || code == (tx ? 0 : 1);
   endfunction : lit

   function automatic logic [31:0] cfg(input logic [3:0] p0);
      return {12'h000, 16'h5431, p0};
   endfunction : cfg

   // Main sequence: registers, framing, LEDs, clock out, power and wakeup.
   initial
   begin
      n = $urandom(32'h0020C779);
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      bus(8'h00, 1'b0, '0);
      check(rd, 32'h0001087A);
      bus(8'h04, 1'b0, '0);
      check(rd, 32'h00054310);
      check({28'h0, pin_oe[3:2], pin_o[3:2]}, 32'hE);
      bus(8'h0C, 1'b1, '1);
      bus(8'h0C, 1'b0, '0);
      check(rd, '0);
      for (int c = 0; c < 3; c++)
      begin
         @(posedge clk);
         div = (c == 0) ? 40 : 84 + $urandom % 20;
         e = (div < 84) ? 84 : div;
         rx_ready <= 1'($urandom);
         bus(8'h00, 1'b1, 32'h00010000 | div);
         bus(8'h04, 1'b1, cfg(4'(c)));
         check(rts_n, !rx_ready);
         // Block first: the synchroniser needs four edges to see it.
         stall    <= 1'b1;
         repeat (6) @(posedge clk);
         tx_data  <= 8'($urandom);
         tx_valid <= 1'b1;
         repeat (12) @(negedge clk);
         check(tx_ready, 1'b0);
         @(posedge clk);
         stall <= 1'b0;
         for (n = 0; n == 0 || (tx_ready !== 1'b1 && n < 50); n++)
            @(negedge clk);
         bound(tx_ready);
         @(posedge clk);
         tx_valid <= 1'b0;
         repeat (e + e / 2) @(negedge clk);
         check(txd, 1'b0);
         check(pin_oe[0], lit(c, 1'b1));
         check(pin_oe[1], 1'b0);
         for (int i = 0; i < 8; i++)
         begin
            repeat (e) @(negedge clk);
            got[i] = txd;
         end
         check(got, tx_data);
         repeat (2 * e + STR) @(posedge clk);
         rx_byte <= 8'($urandom);
         send    <= 1'b1;
         @(posedge clk);
         send <= 1'b0;
         repeat (45) @(negedge clk);
         check(pin_oe[0], lit(c, 1'b0));
         repeat (11 * 84 + STR) @(negedge clk);
         check(pin_oe[0], 1'b0);
      end
      // A long low run keeps retriggering the one-shot.
      @(posedge clk);
      rx_byte <= 8'h00;
      send    <= 1'b1;
      @(posedge clk);
      send <= 1'b0;
      repeat (9 * 84 + STR - 5) @(negedge clk);
      check(pin_oe[0], 1'b1);
      repeat (14) @(negedge clk);
      check(pin_oe[0], 1'b0);
      @(posedge clk);
      bus(8'h04, 1'b1, cfg(4'h6));
      n = 0;
      for (int i = 0; i < 1000; i++)
      begin
         @(negedge clk);
         n += int'(pin_o[0] === 1'b1 && p === 1'b0);
         p = pin_o[0];
      end
      check(n >= 47 && n <= 49 && pin_oe[0] === 1'b1, 1'b1);
      @(posedge clk);
      bus(8'h04, 1'b1, cfg(4'h7));
      conf <= 1'b1;
      repeat (3) @(negedge clk);
      check(pin_oe[0], 1'b0);
      check(pin_o[4:3], 2'b10);
      @(posedge clk);
      susp <= 1'b1;
      repeat (3) @(negedge clk);
      check(pin_o[4:3], 2'b01);
      @(posedge clk);
      ring <= 1'b1;
      for (n = 0; n == 0 || (wake !== 1'b1 && n < 12); n++)
         @(negedge clk);
      bound(wake);
      @(posedge clk);
      ring <= 1'b0;
      repeat (WAK + 5) @(negedge clk);
      check(wake, 1'b0);
      @(posedge clk);
      bus(8'h00, 1'b1, 32'h00020054);
      ring <= 1'b1;
      repeat (15) @(negedge clk);
      check(wake, 1'b0);
      check(osc, 1'b1);
      complete_run();
   end

endmodule : csg_aux_pins_test

`default_nettype wire
